// >>> rtl/pmls_map.vh
// Register map, field positions, reset values and codes of the PHY mode and LED select block
`ifndef PMLS_MAP_VH
`define PMLS_MAP_VH

// Register indices; byte address is four times the index
`define PMLS_IDX_MODE_LED 8'h0A
`define PMLS_IDX_MAC_CTRL 8'h0B
`define PMLS_IDX_STATUS 8'h0C

// Register widths and reset values
`define PMLS_MODE_LED_W 16
`define PMLS_MODE_LED_RST 16'h0000
`define PMLS_MODE_LED_WMASK 16'h38FC
`define PMLS_MAC_CTRL_RST 1'h0

// Fields of phy_mode_led_control
`define PMLS_SPEED_BIT 13
`define PMLS_DUPLEX_SELECT_BIT 12
`define PMLS_AUTONEG_ENABLE_MAC_BIT 11
`define PMLS_LSA_HI 7
`define PMLS_LSA_LO 5
`define PMLS_LSB_HI 4
`define PMLS_LSB_LO 2

// Fields of the MAC control register and the status register
`define PMLS_MAC_FDX_BIT 0
`define PMLS_ST_SPEED_BIT 0
`define PMLS_ST_DUPLEX_SELECT_BIT 1
`define PMLS_ST_AUTONEG_ENABLE_MAC_BIT 2
`define PMLS_ST_MACFDX_BIT 3

// LED selector codes
`define PMLS_LED_ANY_LINK 3'h0
`define PMLS_LED_RESERVED 3'h1
`define PMLS_LED_LINK10 3'h2
`define PMLS_LED_FULL_DUPLEX_SELECT 3'h3
`define PMLS_LED_TXRX 3'h4
`define PMLS_LED_LINK100 3'h5
`define PMLS_LED_RX 3'h6
`define PMLS_LED_TX 3'h7

// AHB transfer type bit that marks an active transfer
`define PMLS_HTRANS_ACTIVE_BIT 1

`endif

// >>> rtl/pmls_led_sel.v
// One LED output with its own 3-bit indication selector
`timescale 1ns/100ps
`default_nettype none
`include "pmls_map.vh"

module pmls_led_sel (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Selector
    input wire [2:0] sel,
    // Indications
    input wire link10_indication,
    input wire full_duplex_indication,
    input wire txrx_activity_indication,
    input wire link100_indication,
    input wire rx_activity_indication,
    input wire tx_activity_indication,
    // LED pin level
    output reg led_out
);

    reg led_next;

    always @* begin
        case (sel)
            `PMLS_LED_ANY_LINK: led_next = link100_indication | link10_indication;
            `PMLS_LED_RESERVED: led_next = 1'b0;
            `PMLS_LED_LINK10: led_next = link10_indication;
            `PMLS_LED_FULL_DUPLEX_SELECT: led_next = full_duplex_indication;
            `PMLS_LED_TXRX: led_next = txrx_activity_indication;
            `PMLS_LED_LINK100: led_next = link100_indication;
            `PMLS_LED_RX: led_next = rx_activity_indication;
            `PMLS_LED_TX: led_next = tx_activity_indication;
            default: led_next = 1'b0;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led_out <= 1'b0;
        end else begin
            led_out <= led_next;
        end
    end

endmodule // pmls_led_sel
`default_nettype wire

// >>> rtl/pmls_top.v
// PHY speed, duplex and mode resolution with two LED selectors behind an AHB-Lite slave
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "pmls_map.vh"

module pmls_top (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // PHY control register 0 bits
    input wire phy_autoneg_enable,
    input wire phy_ctrl_speed_100,
    input wire phy_ctrl_full_duplex,
    // Auto-negotiation outcome
    input wire autoneg_enable_mac_result_speed_100,
    input wire autoneg_enable_mac_result_full_duplex,
    // Indications from the PHY
    input wire link10_indication,
    input wire full_duplex_indication,
    input wire txrx_activity_indication,
    input wire link100_indication,
    input wire rx_activity_indication,
    input wire tx_activity_indication,
    // Resolved PHY and MAC mode
    output reg phy_speed_100,
    output reg phy_full_duplex,
    output reg phy_autoneg_mode,
    output reg mac_full_duplex,
    // LED pins
    output wire led_out_a,
    output wire led_out_b
);

    // Byte address of a register index
    function [31:0] pmls_byte_addr;
        input [7:0] idx;
        begin
            pmls_byte_addr = {22'h000000, idx, 2'h0};
        end
    endfunction

    // Whole-word match of the captured address against a register index
    function pmls_addr_hit;
        input [31:0] addr;
        input [7:0] idx;
        begin
            pmls_addr_hit = (addr == pmls_byte_addr(idx));
        end
    endfunction

    reg [15:0] mode_led_reg;
    reg mac_fdx_reg;
    reg pend_reg;
    reg wr_reg;
    reg [31:0] addr_reg;
    reg speed_next;
    reg duplex_select_next;
    reg autoneg_enable_mac_mode_next;
    reg [31:0] rdata_next;
    wire accept;
    wire autoneg_enable_mac_mac;
    wire hit_mode_led;
    wire hit_mac_ctrl;
    wire hit_status;
    wire wr_strobe;
    wire rd_strobe;

    assign accept = hsel & htrans[`PMLS_HTRANS_ACTIVE_BIT] & hready;
    assign autoneg_enable_mac_mac = mode_led_reg[`PMLS_AUTONEG_ENABLE_MAC_BIT];

    // Register selects for the data phase; the address is held from the address phase
    assign hit_mode_led = pmls_addr_hit(addr_reg, `PMLS_IDX_MODE_LED);
    assign hit_mac_ctrl = pmls_addr_hit(addr_reg, `PMLS_IDX_MAC_CTRL);
    assign hit_status = pmls_addr_hit(addr_reg, `PMLS_IDX_STATUS);
    assign wr_strobe = pend_reg & wr_reg;
    assign rd_strobe = pend_reg & ~wr_reg;

    // Address phase capture and one wait state in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_reg <= 1'b0;
            wr_reg <= 1'b0;
            addr_reg <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            if (pend_reg) begin
                pend_reg <= 1'b0;
                hreadyout <= 1'b1;
            end else if (accept) begin
                pend_reg <= 1'b1;
                wr_reg <= hwrite;
                addr_reg <= haddr;
                hreadyout <= 1'b0;
            end
            hresp <= 1'b0;
        end
    end

    // Read data, unmapped addresses read as zero
    always @* begin
        rdata_next = 32'h00000000;
        if (hit_mode_led) begin
            rdata_next = {16'h0000, mode_led_reg};
        end else if (hit_mac_ctrl) begin
            rdata_next[`PMLS_MAC_FDX_BIT] = mac_fdx_reg;
        end else if (hit_status) begin
            rdata_next[`PMLS_ST_SPEED_BIT] = phy_speed_100;
            rdata_next[`PMLS_ST_DUPLEX_SELECT_BIT] = phy_full_duplex;
            rdata_next[`PMLS_ST_AUTONEG_ENABLE_MAC_BIT] = phy_autoneg_mode;
            rdata_next[`PMLS_ST_MACFDX_BIT] = mac_full_duplex;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_strobe) begin
            hrdata <= rdata_next;
        end
    end

    // Mode and LED select register written in the data phase; reserved bits stay zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_led_reg <= `PMLS_MODE_LED_RST;
        end else if (wr_strobe && hit_mode_led) begin
            mode_led_reg <= hwdata[15:0] & `PMLS_MODE_LED_WMASK;
        end
    end

    // MAC duplex control register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mac_fdx_reg <= `PMLS_MAC_CTRL_RST;
        end else if (wr_strobe && hit_mac_ctrl) begin
            mac_fdx_reg <= hwdata[`PMLS_MAC_FDX_BIT];
        end
    end

    // Speed, duplex and mode resolution
    always @* begin
        autoneg_enable_mac_mode_next = autoneg_enable_mac_mac & phy_autoneg_enable;
        if (!autoneg_enable_mac_mac) begin
            speed_next = mode_led_reg[`PMLS_SPEED_BIT];
            duplex_select_next = mode_led_reg[`PMLS_DUPLEX_SELECT_BIT];
        end else if (phy_autoneg_enable) begin
            speed_next = autoneg_enable_mac_result_speed_100;
            duplex_select_next = autoneg_enable_mac_result_full_duplex;
        end else begin
            speed_next = phy_ctrl_speed_100;
            duplex_select_next = phy_ctrl_full_duplex;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phy_speed_100 <= 1'b0;
            phy_full_duplex <= 1'b0;
            phy_autoneg_mode <= 1'b0;
            mac_full_duplex <= 1'b0;
        end else begin
            phy_speed_100 <= speed_next;
            phy_full_duplex <= duplex_select_next;
            phy_autoneg_mode <= autoneg_enable_mac_mode_next;
            mac_full_duplex <= mac_fdx_reg;
        end
    end

    // LED selectors
    pmls_led_sel u_led_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .sel(mode_led_reg[`PMLS_LSA_HI:`PMLS_LSA_LO]),
        .link10_indication(link10_indication),
        .full_duplex_indication(full_duplex_indication),
        .txrx_activity_indication(txrx_activity_indication),
        .link100_indication(link100_indication),
        .rx_activity_indication(rx_activity_indication),
        .tx_activity_indication(tx_activity_indication),
        .led_out(led_out_a)
    );

    pmls_led_sel u_led_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .sel(mode_led_reg[`PMLS_LSB_HI:`PMLS_LSB_LO]),
        .link10_indication(link10_indication),
        .full_duplex_indication(full_duplex_indication),
        .txrx_activity_indication(txrx_activity_indication),
        .link100_indication(link100_indication),
        .rx_activity_indication(rx_activity_indication),
        .tx_activity_indication(tx_activity_indication),
        .led_out(led_out_b)
    );

endmodule // pmls_top
`default_nettype wire

// >>> bench/pmls_monitor.sv
// Checker of mode resolution and LED selection at the top ports
`timescale 1ns/100ps
`default_nettype none
module pmls_monitor (
    // Clock, reset and bus
    input wire logic hclk, hresetn, hsel, hwrite, hreadyout,
    input wire logic [31:0] haddr, hwdata,
    input wire logic [1:0] htrans,
    // PHY side
    input wire logic phy_autoneg_enable, phy_ctrl_speed_100, phy_ctrl_full_duplex,
    input wire logic autoneg_enable_mac_result_speed_100, autoneg_enable_mac_result_full_duplex,
    input wire logic link10_indication, full_duplex_indication, txrx_activity_indication,
    input wire logic link100_indication, rx_activity_indication, tx_activity_indication,
    // Results
    input wire logic phy_speed_100, phy_full_duplex, phy_autoneg_mode, led_out_a, led_out_b
);
    logic live, pend;
    logic [15:0] sh, shq;
    logic [7:0] vq;
    // Shadow of the mode register and last indications
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {live, pend, sh, shq, vq} <= '0;
        end else begin
            live <= 1'b1;
            pend <= hsel && htrans[1] && hreadyout && hwrite && haddr == 32'h0000_0028;
            sh <= pend ? (hwdata[15:0] & 16'h38FC) : sh;
            shq <= sh;
            vq <= {tx_activity_indication, rx_activity_indication, link100_indication, txrx_activity_indication,
                full_duplex_indication, link10_indication, 1'b0, link100_indication | link10_indication};
        end
    end
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn || !live);
    AST_MAN_SPEED: assert property (!$past(sh[11]) |-> phy_speed_100 == $past(sh[13]))
        else $error("speed not from register bit");
    AST_MAN_DUPLEX_SELECT: assert property (!shq[11] |-> phy_full_duplex == shq[12])
        else $error("duplex not from register bit");
    AST_NEG_SPEED: assert property ($past(sh[11]) && $past(phy_autoneg_enable) |->
        phy_speed_100 == $past(autoneg_enable_mac_result_speed_100)) else $error("speed not from negotiation");
    AST_CTRL_SPEED: assert property (shq[11] && !$past(phy_autoneg_enable) |->
        phy_speed_100 == $past(phy_ctrl_speed_100)) else $error("speed not from PHY control");
    AST_AUTONEG_ENABLE_MAC_DUPLEX_SELECT: assert property ($past(sh[11]) |-> phy_full_duplex ==
        ($past(phy_autoneg_enable) ? $past(autoneg_enable_mac_result_full_duplex) : $past(phy_ctrl_full_duplex)))
        else $error("duplex source wrong");
    AST_MODE: assert property (phy_autoneg_mode == (shq[11] && $past(phy_autoneg_enable)))
        else $error("negotiation mode wrong");
    AST_LED_A: assert property (led_out_a == vq[shq[7:5]])
        else $error("led a wrong");
    AST_LED_B: assert property (led_out_b == vq[shq[4:2]])
        else $error("led b wrong");
endmodule // pmls_monitor
`default_nettype wire

// >>> bench/pmls_phy_model.sv
// Model of PHY control bits, negotiation outcome and indications
`timescale 1ns/100ps
`default_nettype none
module pmls_phy_model (
    // Clock, reset and requested state
    input wire logic hclk, hresetn,
    input wire logic [10:0] knobs,
    // PHY outputs
    output logic phy_autoneg_enable, phy_ctrl_speed_100, phy_ctrl_full_duplex,
    output logic autoneg_enable_mac_result_speed_100, autoneg_enable_mac_result_full_duplex,
    output logic link10_indication, full_duplex_indication, txrx_activity_indication,
    output logic link100_indication, rx_activity_indication, tx_activity_indication
);
    logic [10:0] st;
    // PHY state moves just after a clock edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= 11'h000;
        end else begin
            st <= knobs;
        end
    end
    assign {tx_activity_indication, rx_activity_indication, link100_indication, txrx_activity_indication,
        full_duplex_indication, link10_indication, autoneg_enable_mac_result_full_duplex, autoneg_enable_mac_result_speed_100,
        phy_ctrl_full_duplex, phy_ctrl_speed_100, phy_autoneg_enable} = st;
endmodule // pmls_phy_model
`default_nettype wire

// >>> bench/pmls_tb_top.sv
// Self-checking bench of the PHY mode and LED select block
`timescale 1ns/100ps
`default_nettype none
module pmls_tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [10:0] knobs = 11'h000;
    logic [15:0] r = 16'h0000;
    logic [10:0] k;
    logic m, spd;
    logic phy_autoneg_enable, phy_ctrl_speed_100, phy_ctrl_full_duplex, autoneg_enable_mac_result_speed_100;
    logic autoneg_enable_mac_result_full_duplex, link10_indication, full_duplex_indication, txrx_activity_indication;
    logic link100_indication, rx_activity_indication, tx_activity_indication;
    logic phy_speed_100, phy_full_duplex, phy_autoneg_mode, mac_full_duplex, led_out_a, led_out_b;
    int n_mismatch = 0, samples_checked = 0;
    always #2.5 hclk = ~hclk;
    assign hready = hreadyout;
    pmls_top uut (.*);
    pmls_phy_model u_phy (.*);
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One single AHB-Lite word transfer
    task automatic ahb(logic w, logic [31:0] a, logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic test_done();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Reference model of the resolved mode and LEDs
    task automatic check_out();
        logic [7:0] v;
        logic a;
        v = {knobs[10:5], 1'b0, knobs[8] | knobs[5]};
        a = r[11];
        chk("speed", {31'h0, a ? (knobs[0] ? knobs[3] : knobs[1]) : r[13]}, {31'h0, phy_speed_100});
        chk("duplex", {31'h0, a ? (knobs[0] ? knobs[4] : knobs[2]) : r[12]}, {31'h0, phy_full_duplex});
        chk("mode", {31'h0, a & knobs[0]}, {31'h0, phy_autoneg_mode});
        chk("led a", {31'h0, v[r[7:5]]}, {31'h0, led_out_a});
        chk("led b", {31'h0, v[r[4:2]]}, {31'h0, led_out_b});
    endtask
    initial begin
        void'($urandom(68));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h28, 32'h0);
        chk("reg reset", 32'h0, rd);
        check_out();
        ahb(1'b0, 32'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        for (int i = 0; i < 48; i++) begin
            r = 16'($urandom) & 16'h38FC;
            r[7:5] = (i % 8 == 1) ? 3'h0 : 3'(i % 8);
            r[4:2] = ((i + 3) % 8 == 1) ? 3'h0 : 3'((i + 3) % 8);
            k = 11'($urandom);
            if (i % 4 == 0) begin
                r[11] = 1'b1;
                k[0] = 1'b1;
            end
            knobs <= k;
            spd = r[11] ? (k[0] ? k[3] : k[1]) : r[13];
            m = r[11] ? (k[0] ? k[4] : k[2]) : r[12];
            ahb(1'b1, 32'h28, {16'h0, r});
            ahb(1'b1, 32'h2C, {31'h0, m});
            repeat (2) @(posedge hclk);
            check_out();
            chk("mac duplex", {31'h0, m}, {31'h0, mac_full_duplex});
            ahb(1'b0, 32'h28, 32'h0);
            chk("reg readback", {16'h0, r}, rd);
            ahb(1'b0, 32'h2C, 32'h0);
            chk("mac ctrl readback", {31'h0, m}, rd);
            ahb(1'b0, 32'h30, 32'h0);
            chk("status", {28'h0, m, r[11] & k[0], m, spd}, rd);
        end
        test_done();
    end
    initial begin
        repeat (5000) @(posedge hclk);
        n_mismatch++;
        test_done();
    end
endmodule // pmls_tb_top
bind pmls_top pmls_monitor u_mon (.*);
`default_nettype wire
